// ===== common/rspc_pkg.sv
// constants for the reset state priority controller
// assumes a 32-bit register port with byte addresses
package rspc_pkg;
    // register byte offsets
    localparam logic [7:0] RSPC_OFF_CMD  = 8'h00;
    localparam logic [7:0] RSPC_OFF_STAT = 8'h04;
    localparam logic [7:0] RSPC_OFF_MODE = 8'h08;
    // key field, shared by command and mode writes
    localparam int         RSPC_KEY_LSB  = 24;
    localparam int         RSPC_KEY_MSB  = 31;
    localparam logic [7:0] RSPC_KEY_VAL  = 8'hA5;
    // command bits
    localparam int RSPC_CMD_CPU_BIT = 0;
    localparam int RSPC_CMD_PER_BIT = 2;
    localparam int RSPC_CMD_PIN_BIT = 3;
    // status fields
    localparam int RSPC_ST_EDGE_BIT  = 0;
    localparam int RSPC_ST_CAUSE_LSB = 8;
    localparam int RSPC_ST_LEVEL_BIT = 16;
    localparam int RSPC_ST_BUSY_BIT  = 17;
    // mode fields
    localparam int RSPC_MD_UEN_BIT = 0;
    localparam int RSPC_MD_IEN_BIT = 4;
    localparam int RSPC_MD_LEN_LSB = 8;
    localparam int RSPC_MD_LEN_MSB = 11;
    // reset-cause codes and reset values
    localparam logic [2:0] RSPC_CAUSE_GEN  = 3'h0;
    localparam logic [2:0] RSPC_CAUSE_WAKE = 3'h1;
    localparam logic [2:0] RSPC_CAUSE_WDOG = 3'h2;
    localparam logic [2:0] RSPC_CAUSE_SW   = 3'h3;
    localparam logic [2:0] RSPC_CAUSE_USER = 3'h4;
    localparam logic [31:0] RSPC_STAT_RST  = 32'h0000_0001;
    localparam logic [31:0] RSPC_STAT_BKP  = 32'h0000_0000;
    localparam logic [3:0]  RSPC_LEN_RST   = 4'h0;
    // timing in slow clock cycles
    localparam logic [2:0] RSPC_SOFT_TICKS    = 3'h2;
    localparam logic [2:0] RSPC_WDOG_TICKS    = 3'h2;
    localparam logic [2:0] RSPC_STARTUP_TICKS = 3'h2;
    localparam logic [2:0] RSPC_RESYNC_TICKS  = 3'h2;
    localparam logic [16:0] RSPC_PULSE_ONE    = 17'h0_0001;
    // reset states
    typedef enum logic [5:0] {
        RSPC_IDLE   = 6'b00_0001,
        RSPC_BACKUP = 6'b00_0010,
        RSPC_WAKE   = 6'b00_0100,
        RSPC_WDOG   = 6'b00_1000,
        RSPC_SOFT   = 6'b01_0000,
        RSPC_USER   = 6'b10_0000
    } rspc_state_t;
endpackage : rspc_pkg

// ===== logic/rspc_ctrl.sv
// reset state priority controller: arbitration, pin pulse, registers
// assumes master clock clk, slow clock and pins arrive asynchronously,
// watchdog fault and its proc-only flag come from the clk domain
//
// How it works
// - backup beats wake-up beats watchdog beats software beats user reset
// - no software reset accepted while in user reset
// - watchdog fault during software reset moves to watchdog reset
// - pin level ignored during software reset
// - watchdog reset blocks user reset and software commands
// - busy bit 17 set while software reset runs, clears at its end
// - level bit 16 holds the pin sampled every master clock edge
// - pin falling edge sets sticky edge bit 0
// - interrupt while edge bit, irq enable bit 4, user reset disabled
// - status read clears edge bit and so the interrupt
// - keyed command: bit 0 cpu, bit 2 peripherals, bit 3 pin
// - command and mode writes need key 0xA5 in bits 31..24
// - cause codes: 0 general, 1 wake, 2 watchdog, 3 software, 4 user
// - status read leaves the cause field alone
// - status resets to 1 after core reset, 0 after backup reset
// - user enable set: pin low starts user reset; clear: never
// - pin driven low 2^(len+1) slow cycles, len in mode bits 11..8
// - software reset ends on the second slow clock tick after it starts
// - command writes ignored while busy
// - own pin drive never starts a user reset
// - user reset ends after pin high for resync plus startup cycles
`timescale 1ns/100ps
module rspc_ctrl
    import rspc_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [31:0]       wr_data,
    input  wire logic              wr_en,
    input  wire logic              rd_en,
    output logic      [31:0]       rd_data,
    input  wire logic              slow_clock,
    input  wire logic              pin_reset_in,
    output logic                   pin_reset_out,
    output logic                   pin_reset_oe_n,
    input  wire logic              backup_reset_in,
    input  wire logic              core_reset_in,
    input  wire logic              wdog_fault,
    input  wire logic              wdog_proc_only,
    output logic                   cpu_reset,
    output logic                   periph_reset,
    output logic                   ctrl_irq
);

    rspc_state_t state_r;
    rspc_state_t state_nxt;
    logic        pin_s1, pin_s2, pin_s3;
    logic        slk_s1, slk_s2, slk_s3;
    logic        bkp_s1, bkp_s2;
    logic        core_s1, core_s2;
    logic        slow_tick, pin_fall;
    logic        cmd_wr, mode_wr, stat_rd, key_ok, cmd_any, cmd_take;
    logic        sw_busy_r, cmd_cpu_r, cmd_per_r, cmd_pin_r;
    logic        wproc_r;
    logic [2:0]  hold_cnt_r, hold_lim;
    logic        hold_clr, hold_done;
    logic        user_go, self_mask;
    logic [2:0]  drv_d_r;
    logic [16:0] ext_cnt_r, ext_cnt_nxt;
    logic        pulse_start;
    logic        edge_r, pin_level_r;
    logic [2:0]  cause_r;
    logic        mode_uen_r, mode_ien_r;
    logic [3:0]  mode_len_r;

    // two-flop synchronisers; pin and slow clock get a third flop, edge logic compares taps two and three
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_s1  <= 1'b1;
            pin_s2  <= 1'b1;
            pin_s3  <= 1'b1;
            slk_s1  <= 1'b0;
            slk_s2  <= 1'b0;
            slk_s3  <= 1'b0;
            bkp_s1  <= 1'b0;
            bkp_s2  <= 1'b0;
            core_s1 <= 1'b0;
            core_s2 <= 1'b0;
        end else begin
            pin_s1  <= pin_reset_in;
            pin_s2  <= pin_s1;
            pin_s3  <= pin_s2;
            slk_s1  <= slow_clock;
            slk_s2  <= slk_s1;
            slk_s3  <= slk_s2;
            bkp_s1  <= backup_reset_in;
            bkp_s2  <= bkp_s1;
            core_s1 <= core_reset_in;
            core_s2 <= core_s1;
        end
    end

    // slow clock rising edge as a one-cycle tick
    assign slow_tick = slk_s2 & ~slk_s3;
    assign pin_fall  = pin_s3 & ~pin_s2;

    // register decode
    assign cmd_wr  = wr_en && (addr == ADDR_W'(RSPC_OFF_CMD));
    assign mode_wr = wr_en && (addr == ADDR_W'(RSPC_OFF_MODE));
    assign stat_rd = rd_en && (addr == ADDR_W'(RSPC_OFF_STAT));
    assign key_ok  = wr_data[RSPC_KEY_MSB:RSPC_KEY_LSB] == RSPC_KEY_VAL;
    assign cmd_any = wr_data[RSPC_CMD_CPU_BIT] |
                     wr_data[RSPC_CMD_PER_BIT] |
                     wr_data[RSPC_CMD_PIN_BIT];
    // only idle takes a command: user and watchdog states hold the cpu
    assign cmd_take = cmd_wr && key_ok && cmd_any
                   && !sw_busy_r
                   && state_r == RSPC_IDLE
                   && !wdog_fault && !bkp_s2 && !core_s2;

    // our own drive and its trip back through the pin synchroniser
    assign self_mask = !pin_reset_oe_n || (drv_d_r != 3'h0);
    assign user_go   = mode_uen_r && !pin_s2 && !self_mask;

    // cycles a state holds once its cause has gone
    always_comb begin
        unique case (state_r)
            RSPC_USER: hold_lim = RSPC_RESYNC_TICKS
                                + RSPC_STARTUP_TICKS;
            RSPC_WDOG: hold_lim = RSPC_WDOG_TICKS;
            RSPC_SOFT: hold_lim = RSPC_SOFT_TICKS;
            default:   hold_lim = RSPC_STARTUP_TICKS;
        endcase
    end

    assign hold_clr = (state_r == RSPC_BACKUP && bkp_s2)
                   || (state_r == RSPC_WAKE && core_s2)
                   || (state_r == RSPC_USER && !pin_s2);
    assign hold_done = slow_tick && !hold_clr
                    && (hold_cnt_r == hold_lim - 3'h1);

    // priority arbitration of reset sources
    always_comb begin
        state_nxt = state_r;
        if (bkp_s2) begin
            state_nxt = RSPC_BACKUP;
        end else if (core_s2) begin
            state_nxt = RSPC_WAKE;
        end else begin
            unique case (state_r)
                RSPC_IDLE: begin
                    if (wdog_fault) begin
                        state_nxt = RSPC_WDOG;
                    end else if (sw_busy_r) begin
                        state_nxt = RSPC_SOFT;
                    end else if (user_go) begin
                        state_nxt = RSPC_USER;
                    end
                end
                RSPC_SOFT: begin
                    // pin is not looked at here
                    if (wdog_fault) begin
                        state_nxt = RSPC_WDOG;
                    end else if (hold_done) begin
                        state_nxt = RSPC_IDLE;
                    end
                end
                // no way from watchdog or user into another reset
                RSPC_BACKUP, RSPC_WAKE, RSPC_WDOG, RSPC_USER: begin
                    if (hold_done) begin
                        state_nxt = RSPC_IDLE;
                    end
                end
            endcase
        end
    end

    // state and hold counter
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r    <= RSPC_IDLE;
            hold_cnt_r <= 3'h0;
        end else begin
            state_r <= state_nxt;
            if (state_nxt != state_r || hold_clr) begin
                hold_cnt_r <= 3'h0;
            end else if (slow_tick) begin
                hold_cnt_r <= hold_cnt_r + 3'h1;
            end
        end
    end

    // software command latch and busy flag
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sw_busy_r <= 1'b0;
            cmd_cpu_r <= 1'b0;
            cmd_per_r <= 1'b0;
            cmd_pin_r <= 1'b0;
        end else if (cmd_take) begin
            sw_busy_r <= 1'b1;
            cmd_cpu_r <= wr_data[RSPC_CMD_CPU_BIT];
            cmd_per_r <= wr_data[RSPC_CMD_PER_BIT];
            cmd_pin_r <= wr_data[RSPC_CMD_PIN_BIT];
        end else if (sw_busy_r && state_nxt != RSPC_SOFT) begin
            // end of soft, or a higher reset beat it: the command is dropped
            sw_busy_r <= 1'b0;
            cmd_cpu_r <= 1'b0;
            cmd_per_r <= 1'b0;
            cmd_pin_r <= 1'b0;
        end
    end

    // watchdog flavour is caught on entry and held for the state
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wproc_r <= 1'b0;
        end else if (state_nxt == RSPC_WDOG
                     && state_r != RSPC_WDOG) begin
            wproc_r <= wdog_proc_only;
        end
    end

    // pin pulse: which entries drive the line low; backup and wake reload it on every cycle they last
    assign pulse_start = (state_nxt != state_r) && (
                 (state_nxt == RSPC_WDOG && !wdog_proc_only)
              || (state_nxt == RSPC_SOFT && cmd_pin_r)
              || state_nxt == RSPC_USER)
              || state_nxt == RSPC_BACKUP
              || state_nxt == RSPC_WAKE;

    always_comb begin
        if (pulse_start) begin
            ext_cnt_nxt = RSPC_PULSE_ONE
                        << ({1'b0, mode_len_r} + 5'h01);
        end else if (slow_tick && ext_cnt_r != 17'h0_0000) begin
            ext_cnt_nxt = ext_cnt_r - RSPC_PULSE_ONE;
        end else begin
            ext_cnt_nxt = ext_cnt_r;
        end
    end

    // open-drain pin: value is always low, enable does the work
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ext_cnt_r      <= 17'h0_0000;
            pin_reset_out  <= 1'b0;
            pin_reset_oe_n <= 1'b1;
            drv_d_r        <= 3'h0;
        end else begin
            ext_cnt_r      <= ext_cnt_nxt;
            pin_reset_out  <= 1'b0;
            pin_reset_oe_n <= (ext_cnt_nxt == 17'h0_0000);
            drv_d_r        <= {drv_d_r[1:0], !pin_reset_oe_n};
        end
    end

    // internal reset outputs follow the next state, so no lag
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cpu_reset    <= 1'b0;
            periph_reset <= 1'b0;
        end else begin
            cpu_reset <= state_nxt == RSPC_BACKUP
                      || state_nxt == RSPC_WAKE
                      || state_nxt == RSPC_WDOG
                      || state_nxt == RSPC_USER
                      || (state_nxt == RSPC_SOFT && cmd_cpu_r);
            periph_reset <= state_nxt == RSPC_BACKUP
                      || state_nxt == RSPC_WAKE
                      || state_nxt == RSPC_USER
                      || (state_nxt == RSPC_WDOG && (state_r ==
                          RSPC_WDOG ? !wproc_r : !wdog_proc_only))
                      || (state_nxt == RSPC_SOFT && cmd_per_r);
        end
    end

    // cause is loaded when the cpu reset is let go, and set to its backup value while backup reset is seen
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cause_r <= RSPC_STAT_RST[RSPC_ST_CAUSE_LSB+:3];
        end else if (state_r != RSPC_IDLE
                     && state_nxt == RSPC_IDLE) begin
            unique case (state_r)
                RSPC_BACKUP: cause_r <= RSPC_CAUSE_GEN;
                RSPC_WAKE:   cause_r <= RSPC_CAUSE_WAKE;
                RSPC_WDOG:   cause_r <= RSPC_CAUSE_WDOG;
                RSPC_USER:   cause_r <= RSPC_CAUSE_USER;
                default: begin
                    if (cmd_cpu_r) begin
                        cause_r <= RSPC_CAUSE_SW;
                    end
                end
            endcase
        end else if (bkp_s2) begin
            cause_r <= RSPC_STAT_BKP[RSPC_ST_CAUSE_LSB+:3];
        end
    end

    // sticky edge flag; a new edge wins over the read that clears
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            edge_r      <= RSPC_STAT_RST[RSPC_ST_EDGE_BIT];
            pin_level_r <= 1'b1;
        end else begin
            pin_level_r <= pin_s2;
            if (bkp_s2) begin
                edge_r <= RSPC_STAT_BKP[RSPC_ST_EDGE_BIT];
            end else if (pin_fall) begin
                edge_r <= 1'b1;
            end else if (stat_rd) begin
                edge_r <= 1'b0;
            end
        end
    end

    // mode register, backed-up fields cleared by backup reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mode_uen_r <= 1'b0;
            mode_ien_r <= 1'b0;
            mode_len_r <= RSPC_LEN_RST;
        end else if (bkp_s2) begin
            mode_uen_r <= 1'b0;
            mode_ien_r <= 1'b0;
            mode_len_r <= RSPC_LEN_RST;
        end else if (mode_wr && key_ok) begin
            mode_uen_r <= wr_data[RSPC_MD_UEN_BIT];
            mode_ien_r <= wr_data[RSPC_MD_IEN_BIT];
            mode_len_r <= wr_data[RSPC_MD_LEN_MSB:RSPC_MD_LEN_LSB];
        end
    end

    // interrupt is a level, one cycle behind the flag
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_irq <= 1'b0;
        end else begin
            ctrl_irq <= edge_r && mode_ien_r && !mode_uen_r;
        end
    end

    // read data stands one cycle after the strobe, zero otherwise
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_data <= 32'h0000_0000;
        end else begin
            rd_data <= 32'h0000_0000;
            if (rd_en && addr == ADDR_W'(RSPC_OFF_STAT)) begin
                rd_data[RSPC_ST_EDGE_BIT]        <= edge_r;
                rd_data[RSPC_ST_CAUSE_LSB+:3]    <= cause_r;
                rd_data[RSPC_ST_LEVEL_BIT]       <= pin_level_r;
                rd_data[RSPC_ST_BUSY_BIT]        <= sw_busy_r;
            end else if (rd_en && addr == ADDR_W'(RSPC_OFF_MODE)) begin
                rd_data[RSPC_MD_UEN_BIT]         <= mode_uen_r;
                rd_data[RSPC_MD_IEN_BIT]         <= mode_ien_r;
                rd_data[RSPC_MD_LEN_MSB:RSPC_MD_LEN_LSB] <= mode_len_r;
            end
        end
    end

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_good_cmd;
        cmd_take;
    endsequence
    sequence s_soft_run;
        sw_busy_r ##1 (state_r == RSPC_SOFT);
    endsequence

    a_cmd_starts_soft: assert property (
        s_good_cmd |=> s_soft_run or (sw_busy_r ##1
            state_r inside {RSPC_WDOG, RSPC_BACKUP, RSPC_WAKE}))
        else $error("keyed command did not start software reset");

    a_bad_key_drop: assert property (
        (cmd_wr && !key_ok && !sw_busy_r) |=> !sw_busy_r)
        else $error("command with wrong key was taken");

    a_busy_blocks_cmd: assert property (
        (sw_busy_r && cmd_wr && state_r == RSPC_SOFT)
        |=> $stable(cmd_per_r) || !sw_busy_r)
        else $error("command changed while busy");

    a_wdog_preempt: assert property (
        (state_r == RSPC_SOFT && wdog_fault && !bkp_s2 && !core_s2)
        |=> state_r == RSPC_WDOG)
        else $error("watchdog did not pre-empt software reset");

    a_soft_no_user: assert property (
        (state_r inside {RSPC_SOFT, RSPC_WDOG})
        |=> state_r != RSPC_USER && !(sw_busy_r && !$past(sw_busy_r)))
        else $error("illegal move out of software or watchdog");

    a_user_no_cmd: assert property (
        state_r == RSPC_USER |-> !cmd_take)
        else $error("command accepted during user reset");

    a_backup_first: assert property (
        bkp_s2 |=> state_r == RSPC_BACKUP && cpu_reset)
        else $error("backup reset not taken first");

    a_edge_sets: assert property (
        (pin_fall && !bkp_s2) |=> edge_r ##1 $stable(edge_r) || stat_rd
            || $past(stat_rd))
        else $error("pin falling edge lost");

    a_read_clears: assert property (
        (stat_rd && !pin_fall && !bkp_s2) |=> !edge_r ##1 !ctrl_irq)
        else $error("status read did not clear edge and irq");

    a_irq_level: assert property (
        (edge_r && mode_ien_r && !mode_uen_r) [*2] |-> ctrl_irq)
        else $error("interrupt missing");

    a_cause_stable: assert property (
        (stat_rd && state_r == RSPC_IDLE && state_nxt == RSPC_IDLE
         && !bkp_s2) |=> $stable(cause_r))
        else $error("status read changed the cause");

    a_level_follow: assert property (
        pin_level_r == $past(pin_s2))
        else $error("pin level not tracking");

    a_user_gate: assert property (
        (state_r == RSPC_IDLE && state_nxt == RSPC_USER)
        |-> mode_uen_r && !self_mask)
        else $error("user reset without enable or from own drive");

endmodule : rspc_ctrl

// ===== sim/rspc_ext_dev.sv
// far-side device on the shared reset line; the line has a pull-up
// assumes oe_n low with out low means the controller pulls the line
`timescale 1ns/100ps
module rspc_ext_dev (
    input  wire logic       slow_clock,
    input  wire logic       dev_out,
    input  wire logic       dev_oe_n,
    input  wire logic       ext_pull,
    output logic            line,
    output logic [7:0]      low_ticks
);
    bit was_low;
    // wired-and: any driver low wins, otherwise the pull-up
    assign line = ((!dev_oe_n && !dev_out) || ext_pull) ? 1'b0 : 1'b1;
    // raw slow edges while the controller pulls; a new pull restarts
    always @(posedge slow_clock) begin
        if (!dev_oe_n) low_ticks <= was_low ? low_ticks + 8'h01 : 8'h01;
        was_low <= !dev_oe_n;
    end
endmodule : rspc_ext_dev

// ===== sim/tb_top.sv
// self-checking bench for the reset state priority controller
// assumes rspc_ext_dev on the line and a slow clock of 8 clk periods
`timescale 1ns/100ps
module tb_top
    import rspc_pkg::*;
;
    localparam logic [31:0] KEY = {RSPC_KEY_VAL, 24'h00_0000};
    localparam logic [31:0] LVL = 32'h0001_0000;
    logic        clk, rst, wr_en, rd_en, slow_clock, pin_line, ext_pull;
    logic        backup_reset_in, core_reset_in, wdog_fault, wdog_proc_only;
    logic        pin_reset_out, pin_reset_oe_n, cpu_reset, periph_reset;
    logic        ctrl_irq;
    logic [7:0]  addr, low_ticks;
    logic [31:0] wr_data, rd_data, v, mexp, nm;
    logic [3:0]  len;
    logic [2:0]  cause;
    int          miscompares, tests_run, seed, i, n, e;
    bit          cpu_was;

    rspc_ctrl rspc_ctrl_inst (.clk(clk), .rst(rst), .addr(addr),
        .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
        .slow_clock(slow_clock), .pin_reset_in(pin_line),
        .pin_reset_out(pin_reset_out), .pin_reset_oe_n(pin_reset_oe_n),
        .backup_reset_in(backup_reset_in), .core_reset_in(core_reset_in),
        .wdog_fault(wdog_fault), .wdog_proc_only(wdog_proc_only),
        .cpu_reset(cpu_reset), .periph_reset(periph_reset),
        .ctrl_irq(ctrl_irq));
    rspc_ext_dev rspc_ext_dev_inst (.slow_clock(slow_clock),
        .dev_out(pin_reset_out), .dev_oe_n(pin_reset_oe_n),
        .ext_pull(ext_pull), .line(pin_line), .low_ticks(low_ticks));

    // clocks: slow edges fall on master falling edges, between rising ones
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        slow_clock = 1'b0;
        forever #40 slow_clock = ~slow_clock;
    end

    // length in clk cycles of the latest cpu reset pulse
    always @(posedge clk) begin
        if (cpu_reset === 1'b1) n <= cpu_was ? n + 1 : 1;
        cpu_was <= (cpu_reset === 1'b1);
    end

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : tally_and_finish

    task automatic chk(input string nme, input logic [31:0] s, x);
        tests_run++;
        if (s !== x) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nme, x, s);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr    <= a;
        wr_data <= d;
        wr_en   <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 v = rd_data;
    endtask : rd

    // bounded wait for every reset and the pin pulse to end
    // polled on the falling edge, where the outputs have settled
    task automatic settle();
        repeat (3) @(posedge clk);
        @(negedge clk);
        for (i = 0; i < 600 && (cpu_reset !== 1'b0 ||
             pin_reset_oe_n !== 1'b1 || periph_reset !== 1'b0); i++) begin
            @(negedge clk);
        end
        chk("settle", 32'(i < 600), 1);
        repeat (2) @(posedge clk);
    endtask : settle

    task automatic pull(input int cyc);
        ext_pull <= 1'b1;
        repeat (cyc) @(posedge clk);
        ext_pull <= 1'b0;
    endtask : pull

    function automatic logic [31:0] mv(logic [3:0] l, logic ie, ue);
        return {20'h0_0000, l, 3'h0, ie, 3'h0, ue};
    endfunction : mv

    initial begin
        rst = 1'b1;
        {wr_en, rd_en, ext_pull, backup_reset_in} = 4'h0;
        {core_reset_in, wdog_fault, wdog_proc_only} = 3'h0;
        addr = 8'h00;
        wr_data = 32'h0000_0000;
        seed = 72276;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        // reset values, command and unmapped reads
        rd(RSPC_OFF_STAT);
        chk("stat_rst", v, RSPC_STAT_RST | LVL);
        rd(RSPC_OFF_MODE);
        chk("mode_rst", v, 32'h0000_0000);
        rd(RSPC_OFF_CMD);
        chk("cmd_read", v, 32'h0000_0000);
        rd(8'h0C);
        chk("unmapped", v, 32'h0000_0000);
        // random mode writes, odd ones with a wrong key
        mexp = 32'h0000_0000;
        for (int k = 0; k < 8; k++) begin
            len = 4'({$random(seed)} % 3);
            nm = mv(len, 1'($random(seed)), 1'b0);
            wr(RSPC_OFF_MODE, nm | ($random(seed) & 32'h00FE_F0EE) |
               ((k % 2 == 0) ? KEY : 32'h5A00_0000));
            if (k % 2 == 0) mexp = nm;
            rd(RSPC_OFF_MODE);
            chk("mode_rw", v, mexp);
        end
        // pin edge with user reset off raises the interrupt
        wr(RSPC_OFF_MODE, KEY | mv(len, 1'b1, 1'b0));
        pull(6);
        repeat (8) @(posedge clk);
        chk("irq_set", 32'(ctrl_irq), 1);
        chk("no_user", 32'(cpu_reset), 0);
        rd(RSPC_OFF_STAT);
        cause = v[10:8];
        chk("edge_set", 32'(v[0]), 1);
        repeat (2) @(posedge clk);
        chk("irq_clr", 32'(ctrl_irq), 0);
        rd(RSPC_OFF_STAT);
        chk("edge_clr", v & 32'h0001_0001, LVL);
        chk("cause_kept", 32'(v[10:8]), 32'(cause));
        // keyed software reset with pin drive; user reset enabled
        wr(RSPC_OFF_MODE, KEY | mv(len, 1'b0, 1'b1));
        wr(RSPC_OFF_CMD, KEY | 32'h0000_0009);
        rd(RSPC_OFF_STAT);
        chk("busy_set", 32'(v[17]), 1);
        chk("cpu_rst", 32'(cpu_reset), 1);
        wr(RSPC_OFF_CMD, KEY | 32'h0000_0004);
        repeat (2) @(posedge clk);
        chk("busy_ign", 32'(periph_reset), 0);
        settle();
        e = 1 << (len + 1);
        // raw slow edges lead the resynced ticks: one may precede the pull
        chk("pulse", 32'(low_ticks >= e - 1 && low_ticks <= e), 1);
        chk("soft_len", 32'(n >= 9 && n <= 16), 1);
        rd(RSPC_OFF_STAT);
        chk("soft_done", v & 32'h0003_0700, 32'h0001_0300);
        // wrong key refused, then peripheral-only command
        wr(RSPC_OFF_CMD, 32'h5A00_0005);
        repeat (3) @(posedge clk);
        chk("bad_key", 32'({cpu_reset, periph_reset}), 0);
        wr(RSPC_OFF_CMD, KEY | 32'h0000_0004);
        repeat (2) @(posedge clk);
        chk("per_only", 32'({cpu_reset, periph_reset}), 1);
        settle();
        // user reset from the pin; commands refused meanwhile
        ext_pull <= 1'b1;
        repeat (8) @(posedge clk);
        chk("user_rst", 32'({cpu_reset, periph_reset}), 3);
        wr(RSPC_OFF_CMD, KEY | 32'h0000_0001);
        rd(RSPC_OFF_STAT);
        chk("user_stat", v & 32'h0003_0000, 32'h0000_0000);
        ext_pull <= 1'b0;
        settle();
        rd(RSPC_OFF_STAT);
        chk("user_cause", 32'(v[10:8]), 32'(RSPC_CAUSE_USER));
        // watchdog fault pre-empts a running software reset
        wr(RSPC_OFF_CMD, KEY | 32'h0000_0001);
        @(posedge clk);
        wdog_fault <= 1'b1;
        @(posedge clk);
        wdog_fault <= 1'b0;
        @(posedge clk);
        chk("wdog_per", 32'(periph_reset), 1);
        ext_pull <= 1'b1;
        wr(RSPC_OFF_CMD, KEY | 32'h0000_0001);
        rd(RSPC_OFF_STAT);
        chk("wdog_busy", 32'(v[17]), 0);
        ext_pull <= 1'b0;
        settle();
        rd(RSPC_OFF_STAT);
        chk("wdog_cause", 32'(v[10:8]), 32'(RSPC_CAUSE_WDOG));
        // backup beats a simultaneous watchdog fault
        backup_reset_in <= 1'b1;
        repeat (2) @(posedge clk);
        wdog_fault <= 1'b1;
        repeat (2) @(posedge clk);
        backup_reset_in <= 1'b0;
        wdog_fault <= 1'b0;
        settle();
        rd(RSPC_OFF_STAT);
        chk("bkp_stat", v & 32'hFFFF_FFFE, RSPC_STAT_BKP | LVL);
        rd(RSPC_OFF_MODE);
        chk("bkp_mode", v, 32'h0000_0000);
        // watchdog limited to the cpu, then a wake-up reset
        wdog_proc_only <= 1'b1;
        wdog_fault <= 1'b1;
        @(posedge clk);
        wdog_fault <= 1'b0;
        @(posedge clk);
        v = {cpu_reset, periph_reset, pin_reset_oe_n};
        chk("wdog_cpu", v, 5);
        settle();
        core_reset_in <= 1'b1;
        repeat (4) @(posedge clk);
        chk("wake_rst", 32'({cpu_reset, periph_reset}), 3);
        core_reset_in <= 1'b0;
        settle();
        rd(RSPC_OFF_STAT);
        chk("wake_cause", 32'(v[10:8]), 32'(RSPC_CAUSE_WAKE));
        tally_and_finish();
    end

    // hang guard, far beyond the expected few hundred cycles
    initial begin
        #400_000;
        miscompares++;
        tally_and_finish();
    end
endmodule : tb_top
